// >>> pmd_defines.svh
`ifndef PMD_DEFINES_SVH
`define PMD_DEFINES_SVH
// register offsets, 4-bit word address
`define PMD_OFS_MON_SEL   4'h0
`define PMD_OFS_VIEW      4'h1
`define PMD_OFS_SPECIAL   4'h2
`define PMD_OFS_FORCE     4'h3
`define PMD_OFS_PTR0      4'h4
`define PMD_OFS_SEL0      4'h8
`define PMD_OFS_JOG       4'hc
`define PMD_OFS_STATUS    4'hd
`define PMD_OFS_DOUT      4'he
// view control field positions
`define PMD_VIEW_HEX      0
`define PMD_VIEW_HIGH     1
`define PMD_VIEW_WIDE     2
`define PMD_VIEW_MASK     3
// key index
`define PMD_KEY_SET       0
`define PMD_KEY_MODE      1
`define PMD_KEY_UP        2
`define PMD_KEY_DOWN      3
`define PMD_KEY_SHIFT     4
// values and limits
`define PMD_MON_MAX       5'h1a
`define PMD_MON_RST       5'h00
`define PMD_JOG_RST       16'h0014
`define PMD_JOG_MAX       16'h1388
`define PMD_FORCE_ON      16'h0196
`define PMD_FORCE_SW      16'h0190
`define PMD_ZPOS_LIM      32'h0000_1388
`define PMD_FAULT_LAST    3'h4
// timing
`define PMD_CLK_HZ        10000000
`define PMD_BOOT_MS       1000
`define PMD_DEB_MS        10
`define PMD_BOOT_CYC      (`PMD_CLK_HZ / 1000 * `PMD_BOOT_MS)
`define PMD_DEB_CYC       (`PMD_CLK_HZ / 1000 * `PMD_DEB_MS)
// display characters beyond 0..f
`define PMD_CH_BLANK      5'h10
`define PMD_CH_H          5'h11
`define PMD_CH_L          5'h12
`define PMD_CH_N          5'h13
`define PMD_CH_J          5'h14
`define PMD_CH_G          5'h15
`endif

// >>> pmd_keypad.sv
`timescale 1ns/1ns
// operator model: one key at a time, held for a set count, released low
module pmd_keypad (
  input  wire logic       clk_i,
  input  wire logic       go_i,
  input  wire logic [2:0] idx_i,
  input  wire logic [7:0] hold_i,
  output logic [4:0]      key_o
);
  logic [7:0] cnt = 8'h0; // cycles left in the press
  logic [4:0] key = 5'h0; // held key, one-hot, idle low
  assign key_o = key;
  // presses far longer than the bounce window, one event each
  always @(posedge clk_i) begin
    if (go_i) begin
      key <= 5'h01 << idx_i;
      cnt <= hold_i;
    end else if (cnt != 8'h0) cnt <= cnt - 8'h01;
    else key <= 5'h0;
  end
endmodule

// >>> pmd_panel.sv
// Local design decisions: the register offsets and the address-and-strobe port.
`timescale 1ns/1ns
`include "pmd_defines.svh"
module pmd_panel import pmd_pkg::*; #(
  parameter int BOOT_CYC = `PMD_BOOT_CYC,
  parameter int DEB_CYC  = `PMD_DEB_CYC
) (
  input  wire logic              ref_clk_i,
  input  wire logic              srst_i,
  input  wire logic [3:0]        addr_i,
  input  wire logic [31:0]       wdata_i,
  input  wire logic              wr_i,
  input  wire logic              rd_i,
  output logic [31:0]            rdata_o,
  input  wire logic [4:0]        key_i,
  input  wire logic              servo_on_i,
  input  wire pmd_mon_type       mon_i,
  input  wire logic [4:0][15:0]  fault_hist_i,
  input  wire logic [4:0]        do_func_i,
  output logic [4:0]             do_o,
  output logic                   jog_cw_o,
  output logic                   jog_ccw_o,
  output pmd_cfg_type            cfg_o,
  output pmd_disp_type           disp_o
);

  // add 3 to every bcd nibble above 4, one double-dabble step
  function automatic logic [39:0] pmd_add3(input logic [39:0] b);
    logic [39:0] r;
    r = b;
    for (int i = 0; i < 10; i++) begin
      if (r[4*i+:4] > 4'h4) begin
        r[4*i+:4] = r[4*i+:4] + 4'h3;
      end
    end
    return r;
  endfunction

  // four hex nibbles onto the four right characters
  function automatic logic [3:0][4:0] pmd_hex4(input logic [15:0] v);
    logic [3:0][4:0] c;
    for (int i = 0; i < 4; i++) begin
      c[i] = {1'b0, v[4*i+:4]};
    end
    return c;
  endfunction

  // selection code to tens and ones, code never above 31
  function automatic logic [7:0] pmd_dec2(input logic [4:0] s);
    logic [4:0] t;
    t = 5'h00;
    if (s >= 5'h1e) t = 5'h03;
    else if (s >= 5'h14) t = 5'h02;
    else if (s >= 5'h0a) t = 5'h01;
    return {t[3:0], 4'(s - 5'(t * 5'h0a))};
  endfunction

  // ---------------- keys ----------------
  logic [4:0]       k_s1;             // first sync stage
  logic [4:0]       k_s2;             // second sync stage
  logic [4:0]       k_lvl;            // debounced level
  logic [4:0]       k_prev;           // level one cycle ago
  logic [4:0][19:0] k_cnt;            // stability counters
  logic [4:0]       next_k_lvl;
  logic [4:0][19:0] next_k_cnt;
  logic [4:0]       k_evt;            // one pulse per press

  assign k_evt = k_lvl & ~k_prev;

  // a level must hold for DEB_CYC before it is believed
  always_comb begin
    next_k_lvl = k_lvl;
    next_k_cnt = k_cnt;
    for (int i = 0; i < 5; i++) begin
      if (k_s2[i] == k_lvl[i]) begin
        next_k_cnt[i] = 20'h00000;
      end else if (k_cnt[i] >= 20'(DEB_CYC - 1)) begin
        next_k_lvl[i] = k_s2[i];
        next_k_cnt[i] = 20'h00000;
      end else begin
        next_k_cnt[i] = k_cnt[i] + 20'h00001;
      end
    end
  end

  // key pins are asynchronous: two flops before anything reads them
  always_ff @(posedge ref_clk_i) begin
    if (srst_i) begin
      k_s1   <= 5'h00;
      k_s2   <= 5'h00;
      k_lvl  <= 5'h00;
      k_prev <= 5'h00;
      k_cnt  <= '0;
    end else begin
      k_s1   <= key_i;
      k_s2   <= k_s1;
      k_lvl  <= next_k_lvl;
      k_prev <= k_lvl;
      k_cnt  <= next_k_cnt;
    end
  end

  // ---------------- monitor value pick ----------------
  logic [4:0]  mon_sel;               // monitor_select
  logic [31:0] mon_val;

  // code to live value
  always_comb begin
    mon_val = 32'h0000_0000;
    case (mon_sel)
      5'h0b: mon_val = mon_i.torque_pct;
      5'h0c: mon_val = mon_i.avg_load;
      5'h0d: mon_val = mon_i.peak_load;
      5'h0e: mon_val = mon_i.bus_volt;
      5'h0f: mon_val = mon_i.inertia_x10;
      5'h10: mon_val = mon_i.stage_temp;
      5'h11: mon_val = {mon_i.res2_hz, mon_i.res1_hz};
      5'h12: begin
        // clamp keeps a glitchy counter inside the index window
        if ($signed(mon_i.z_pos) > $signed(`PMD_ZPOS_LIM)) begin
          mon_val = `PMD_ZPOS_LIM;
        end else if ($signed(mon_i.z_pos) < -$signed(`PMD_ZPOS_LIM)) begin
          mon_val = -`PMD_ZPOS_LIM;
        end else begin
          mon_val = mon_i.z_pos;
        end
      end
      5'h13, 5'h14, 5'h15, 5'h16: begin
        mon_val = mon_i.slot_val[2'(mon_sel - 5'h13)];
      end
      5'h17, 5'h18, 5'h19, 5'h1a: begin
        mon_val = mon_i.stat_val[2'(mon_sel - 5'h17)];
      end
      default: begin
        if (mon_sel < 5'h0b) mon_val = mon_i.gen[4'(mon_sel)];
      end
    endcase
  end

  // ---------------- settings and panel sequencing ----------------
  pmd_state_type st;
  pmd_state_type next_st;
  logic [3:0]  view;                  // hex, high, wide, mask view
  logic        force_en;              // forced output control armed
  logic [4:0]  force_mask;            // forced_output_mask
  pmd_cfg_type cfg;
  logic [2:0]  fault_idx;             // fault_history_entry position
  logic [1:0]  cursor;                // jog edit digit
  logic [23:0] boot_cnt;
  logic [4:0]  next_mon_sel;
  logic [3:0]  next_view;
  logic        next_force_en;
  logic [4:0]  next_force_mask;
  pmd_cfg_type next_cfg;
  logic [2:0]  next_fault_idx;
  logic [1:0]  next_cursor;
  logic [23:0] next_boot_cnt;
  logic [16:0] jog_step;
  logic [16:0] jog_sum;

  // cursor picks the edited decade
  always_comb begin
    case (cursor)
      2'h0:    jog_step = 17'h00001;
      2'h1:    jog_step = 17'h0000a;
      2'h2:    jog_step = 17'h00064;
      default: jog_step = 17'h003e8;
    endcase
    jog_sum = {1'b0, cfg.jog_speed} + jog_step;
  end

  // keys first, then bus writes, so software has the last word
  always_comb begin
    next_st         = st;
    next_mon_sel    = mon_sel;
    next_view       = view;
    next_force_en   = force_en;
    next_force_mask = force_mask;
    next_cfg        = cfg;
    next_fault_idx  = fault_idx;
    next_cursor     = cursor;
    next_boot_cnt   = boot_cnt;
    case (st)
      st_boot: begin
        // name code first, then the stored selection
        if (boot_cnt >= 24'(BOOT_CYC - 1)) begin
          next_st = st_monitor;
        end else begin
          next_boot_cnt = boot_cnt + 24'h000001;
        end
      end
      st_monitor: begin
        if (k_evt[`PMD_KEY_UP]) begin
          next_mon_sel = (mon_sel >= `PMD_MON_MAX) ? 5'h00 : mon_sel + 5'h01;
        end else if (k_evt[`PMD_KEY_DOWN]) begin
          next_mon_sel = (mon_sel == 5'h00) ? `PMD_MON_MAX : mon_sel - 5'h01;
        end else if (k_evt[`PMD_KEY_SHIFT]) begin
          next_view[`PMD_VIEW_HIGH] = ~view[`PMD_VIEW_HIGH];
        end else if (k_evt[`PMD_KEY_SET]) begin
          next_view[`PMD_VIEW_HEX] = ~view[`PMD_VIEW_HEX];
        end else if (k_evt[`PMD_KEY_MODE]) begin
          next_st = st_fault_name;
        end
      end
      st_fault_name: begin
        if (k_evt[`PMD_KEY_UP]) begin
          next_fault_idx = (fault_idx >= `PMD_FAULT_LAST) ? 3'h0 : fault_idx + 3'h1;
        end else if (k_evt[`PMD_KEY_DOWN]) begin
          next_fault_idx = (fault_idx == 3'h0) ? `PMD_FAULT_LAST : fault_idx - 3'h1;
        end else if (k_evt[`PMD_KEY_SET]) begin
          next_st = st_fault_show;
        end else if (k_evt[`PMD_KEY_MODE]) begin
          next_st = st_jog_name;
        end
      end
      st_fault_show: begin
        if (k_evt[`PMD_KEY_SET] | k_evt[`PMD_KEY_MODE]) next_st = st_fault_name;
      end
      st_jog_name: begin
        if (k_evt[`PMD_KEY_SET]) begin
          next_st     = st_jog_edit;
          next_cursor = 2'h0;
        end else if (k_evt[`PMD_KEY_MODE]) begin
          next_st = st_monitor;
        end
      end
      st_jog_edit: begin
        if (k_evt[`PMD_KEY_UP]) begin
          next_cfg.jog_speed = (jog_sum > {1'b0, `PMD_JOG_MAX}) ?
                               `PMD_JOG_MAX : jog_sum[15:0];
        end else if (k_evt[`PMD_KEY_DOWN]) begin
          next_cfg.jog_speed = ({1'b0, cfg.jog_speed} < jog_step) ?
                               16'h0000 : cfg.jog_speed - jog_step[15:0];
        end else if (k_evt[`PMD_KEY_SHIFT]) begin
          next_cursor = cursor + 2'h1;
        end else if (k_evt[`PMD_KEY_SET] & servo_on_i) begin
          next_st = st_jog_run;
        end else if (k_evt[`PMD_KEY_MODE]) begin
          next_st = st_jog_name;
        end
      end
      st_jog_run: begin
        // losing servo on drops jog back to the entry name
        if (k_evt[`PMD_KEY_MODE] | ~servo_on_i) next_st = st_jog_name;
      end
      default: next_st = st_boot;
    endcase
    if (wr_i) begin
      case (addr_i)
        `PMD_OFS_MON_SEL: begin
          if (wdata_i[31:0] <= {27'h0, `PMD_MON_MAX}) begin
            next_mon_sel = wdata_i[4:0];
          end
        end
        `PMD_OFS_VIEW:  next_view = wdata_i[3:0];
        `PMD_OFS_SPECIAL: begin
          if (wdata_i[15:0] == `PMD_FORCE_ON) next_force_en = 1'b1;
          else if (wdata_i[15:0] == `PMD_FORCE_SW) next_force_en = ~force_en;
        end
        `PMD_OFS_FORCE: next_force_mask = wdata_i[4:0];
        `PMD_OFS_JOG:   next_cfg.jog_speed = wdata_i[15:0];
        default: begin
          if (addr_i[3:2] == 2'h1) next_cfg.slot_ptr[addr_i[1:0]] = wdata_i[15:0];
          if (addr_i[3:2] == 2'h2) next_cfg.stat_sel[addr_i[1:0]] = wdata_i[7:0];
        end
      endcase
    end
  end

  // mask and force never survive a reset
  always_ff @(posedge ref_clk_i) begin
    if (srst_i) begin
      st         <= st_boot;
      mon_sel    <= `PMD_MON_RST;
      view       <= 4'h0;
      force_en   <= 1'b0;
      force_mask <= 5'h00;
      cfg        <= '{slot_ptr: '0, stat_sel: '0, jog_speed: `PMD_JOG_RST};
      fault_idx  <= 3'h0;
      cursor     <= 2'h0;
      boot_cnt   <= 24'h000000;
    end else begin
      st         <= next_st;
      mon_sel    <= next_mon_sel;
      view       <= next_view;
      force_en   <= next_force_en;
      force_mask <= next_force_mask;
      cfg        <= next_cfg;
      fault_idx  <= next_fault_idx;
      cursor     <= next_cursor;
      boot_cnt   <= next_boot_cnt;
    end
  end

  // ---------------- binary to decimal ----------------
  logic [31:0] cv_val;                // value feeding the converter
  logic        cv_signed;
  logic [31:0] dd_sh;
  logic [39:0] dd_bcd;
  logic [5:0]  dd_cnt;
  logic        dd_neg;
  logic [39:0] dd_res;                // last finished ten digits
  logic        dd_res_neg;
  logic [31:0] next_dd_sh;
  logic [39:0] next_dd_bcd;
  logic [5:0]  next_dd_cnt;
  logic        next_dd_neg;
  logic [39:0] next_dd_res;
  logic        next_dd_res_neg;

  // settings go through unsigned, monitors may be negative
  always_comb begin
    cv_signed = 1'b0;
    case (st)
      st_boot:       cv_val = {27'h0, mon_sel};
      st_fault_name,
      st_fault_show: cv_val = {16'h0, fault_hist_i[fault_idx]};
      st_jog_name,
      st_jog_edit,
      st_jog_run:    cv_val = {16'h0, cfg.jog_speed};
      default: begin
        cv_signed = 1'b1;
        cv_val = view[`PMD_VIEW_WIDE] ? mon_val :
                 {{16{mon_val[15]}}, mon_val[15:0]};
      end
    endcase
  end

  // serial double-dabble, a result every 34 cycles; the lag is
  // invisible on a panel but saves ten dividers
  always_comb begin
    next_dd_sh      = dd_sh;
    next_dd_bcd     = dd_bcd;
    next_dd_cnt     = dd_cnt + 6'h01;
    next_dd_neg     = dd_neg;
    next_dd_res     = dd_res;
    next_dd_res_neg = dd_res_neg;
    if (dd_cnt == 6'h00) begin
      next_dd_neg = cv_signed & cv_val[31];
      next_dd_sh  = next_dd_neg ? 32'(-cv_val) : cv_val;
      next_dd_bcd = 40'h00_0000_0000;
    end else if (dd_cnt == 6'h21) begin
      next_dd_res     = dd_bcd;
      next_dd_res_neg = dd_neg;
      next_dd_cnt     = 6'h00;
    end else begin
      {next_dd_bcd, next_dd_sh} = {pmd_add3(dd_bcd), dd_sh} << 1;
    end
  end

  // converter registers
  always_ff @(posedge ref_clk_i) begin
    if (srst_i) begin
      dd_sh      <= 32'h0000_0000;
      dd_bcd     <= 40'h00_0000_0000;
      dd_cnt     <= 6'h00;
      dd_neg     <= 1'b0;
      dd_res     <= 40'h00_0000_0000;
      dd_res_neg <= 1'b0;
    end else begin
      dd_sh      <= next_dd_sh;
      dd_bcd     <= next_dd_bcd;
      dd_cnt     <= next_dd_cnt;
      dd_neg     <= next_dd_neg;
      dd_res     <= next_dd_res;
      dd_res_neg <= next_dd_res_neg;
    end
  end

  // ---------------- display, outputs, read port ----------------
  pmd_disp_type next_disp;
  logic [4:0]   next_do;
  logic [31:0]  next_rdata;
  logic [7:0]   name2;
  logic [15:0]  hex_half;

  assign name2    = pmd_dec2(mon_sel);
  assign hex_half = view[`PMD_VIEW_HIGH] ? mon_val[31:16] : mon_val[15:0];

  // character layout per state and view
  always_comb begin
    next_disp.ch = {5{`PMD_CH_BLANK}};
    next_disp.dp = 5'h00;
    for (int i = 0; i < 5; i++) begin
      next_disp.ch[i] = {1'b0, dd_res[4*i+:4]};
    end
    case (st)
      st_boot: begin
        next_disp.ch = {`PMD_CH_N, `PMD_CH_BLANK, `PMD_CH_BLANK,
                        1'b0, name2[7:4], 1'b0, name2[3:0]};
      end
      st_monitor: begin
        if (view[`PMD_VIEW_MASK]) begin
          next_disp.ch[3:0] = pmd_hex4({11'h000, force_mask});
          next_disp.ch[4]   = `PMD_CH_BLANK;
        end else if (view[`PMD_VIEW_HEX]) begin
          // no sign marks at all in hex
          if (view[`PMD_VIEW_WIDE]) begin
            next_disp.ch[3:0] = pmd_hex4(hex_half);
            next_disp.ch[4]   = view[`PMD_VIEW_HIGH] ? `PMD_CH_H : `PMD_CH_L;
          end else begin
            next_disp.ch[3:0] = pmd_hex4(mon_val[15:0]);
            next_disp.ch[4]   = `PMD_CH_BLANK;
          end
        end else begin
          if (view[`PMD_VIEW_WIDE] & view[`PMD_VIEW_HIGH]) begin
            for (int i = 0; i < 5; i++) begin
              next_disp.ch[i] = {1'b0, dd_res[20+4*i+:4]};
            end
            next_disp.dp[0] = 1'b1;
          end
          if (dd_res_neg) next_disp.dp[4:3] = 2'h3;
        end
      end
      st_fault_name: begin
        next_disp.ch = {5'h0f, `PMD_CH_BLANK, `PMD_CH_BLANK,
                        `PMD_CH_BLANK, 2'h0, fault_idx};
      end
      st_jog_name: begin
        next_disp.ch = {`PMD_CH_J, `PMD_CH_BLANK, `PMD_CH_BLANK,
                        `PMD_CH_BLANK, `PMD_CH_BLANK};
      end
      st_jog_edit: next_disp.dp[cursor] = 1'b1;
      st_jog_run: begin
        next_disp.ch = {`PMD_CH_BLANK, `PMD_CH_BLANK, `PMD_CH_J,
                        5'h00, `PMD_CH_G};
      end
      default: ;
    endcase
  end

  // outputs and read data
  always_comb begin
    // forcing is honoured only with the power stage off
    next_do = (force_en & ~servo_on_i) ? force_mask : do_func_i;
    next_rdata = 32'h0000_0000;
    if (rd_i) begin
      case (addr_i)
        `PMD_OFS_MON_SEL: next_rdata = {27'h0, mon_sel};
        `PMD_OFS_VIEW:    next_rdata = {28'h0, view};
        `PMD_OFS_SPECIAL: next_rdata = {31'h0, force_en};
        `PMD_OFS_FORCE:   next_rdata = {27'h0, force_mask};
        `PMD_OFS_JOG:     next_rdata = {16'h0, cfg.jog_speed};
        `PMD_OFS_STATUS:  next_rdata = {27'h0, st, servo_on_i, dd_res_neg};
        `PMD_OFS_DOUT:    next_rdata = {27'h0, do_o};
        default: begin
          if (addr_i[3:2] == 2'h1) next_rdata = {16'h0, cfg.slot_ptr[addr_i[1:0]]};
          if (addr_i[3:2] == 2'h2) next_rdata = {24'h0, cfg.stat_sel[addr_i[1:0]]};
        end
      endcase
    end
  end

  // every top output comes from here
  always_ff @(posedge ref_clk_i) begin
    if (srst_i) begin
      disp_o    <= '{ch: {5{`PMD_CH_BLANK}}, dp: 5'h00};
      do_o      <= 5'h00;
      jog_cw_o  <= 1'b0;
      jog_ccw_o <= 1'b0;
      cfg_o     <= '{slot_ptr: '0, stat_sel: '0, jog_speed: `PMD_JOG_RST};
      rdata_o   <= 32'h0000_0000;
    end else begin
      disp_o    <= next_disp;
      do_o      <= next_do;
      // held level, not the press pulse, so release stops at once
      jog_cw_o  <= (st == st_jog_run) & servo_on_i & k_lvl[`PMD_KEY_DOWN] &
                   ~k_lvl[`PMD_KEY_UP];
      jog_ccw_o <= (st == st_jog_run) & servo_on_i & k_lvl[`PMD_KEY_UP] &
                   ~k_lvl[`PMD_KEY_DOWN];
      cfg_o     <= cfg;
      rdata_o   <= next_rdata;
    end
  end

endmodule

// >>> pmd_panel_chk.sv
`timescale 1ns/1ns
module pmd_panel_chk import pmd_pkg::*; #(
  parameter int BOOT_CYC = 50,
  parameter int DEB_CYC  = 4
) (
  input wire logic             ref_clk_i,
  input wire logic             srst_i,
  input wire logic [3:0]       addr_i,
  input wire logic [31:0]      wdata_i,
  input wire logic             wr_i,
  input wire logic             rd_i,
  input wire logic [31:0]      rdata_o,
  input wire logic [4:0]       key_i,
  input wire logic             servo_on_i,
  input wire pmd_mon_type      mon_i,
  input wire logic [4:0][15:0] fault_hist_i,
  input wire logic [4:0]       do_func_i,
  input wire logic [4:0]       do_o,
  input wire logic             jog_cw_o,
  input wire logic             jog_ccw_o,
  input wire pmd_cfg_type      cfg_o,
  input wire pmd_disp_type     disp_o
);
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (srst_i);
  // read data stands only in the slot after a read
  rd_zero_a: assert property (!$past(rd_i) |-> rdata_o == 32'h0)
    else $error("read data outside its slot");
  sel_rb_a: assert property (wr_i && addr_i == 4'h0 && wdata_i <= 32'd26 ##2 rd_i && addr_i == 4'h0
    |=> rdata_o == $past(wdata_i, 3)) else $error("monitor selection readback wrong");
  do_rb_a: assert property (rd_i && addr_i == 4'he |=> rdata_o == {27'h0, $past(do_o)})
    else $error("output readback wrong");
  // servo on always hands outputs back to their functions
  do_func_a: assert property (servo_on_i |=> do_o == $past(do_func_i))
    else $error("outputs forced while servo on");
  jog_servo_a: assert property (!servo_on_i |=> !jog_cw_o && !jog_ccw_o)
    else $error("jog while servo off");
  jog_excl_a: assert property (!(jog_cw_o && jog_ccw_o))
    else $error("both jog directions");
  rst_val_a: assert property ($fell(srst_i) |-> do_o == 5'h0 && cfg_o.jog_speed == 16'h0014)
    else $error("reset values wrong");
  boot_name_a: assert property ($fell(srst_i) |-> ##[0:2] disp_o.ch[4] == 5'h13)
    else $error("boot name missing");
  cover property (jog_ccw_o);
  cover property (!servo_on_i && do_o != do_func_i);
  cover property (rd_i && addr_i == 4'h0);
endmodule
bind pmd_panel pmd_panel_chk #(.BOOT_CYC(BOOT_CYC), .DEB_CYC(DEB_CYC)) u_chk (.ref_clk_i, .srst_i,
  .addr_i, .wdata_i, .wr_i, .rd_i, .rdata_o, .key_i, .servo_on_i, .mon_i, .fault_hist_i,
  .do_func_i, .do_o, .jog_cw_o, .jog_ccw_o, .cfg_o, .disp_o);

// >>> pmd_panel_tb.sv
`timescale 1ns/1ns
module pmd_panel_tb import pmd_pkg::*;;
  logic clk = 0, srst = 1, wr = 0, rd = 0, servo = 0, go = 0;
  logic [3:0] addr = 0;
  logic [31:0] wd = 0, rdata, sel = 0, v;
  logic [2:0] idx = 0;
  logic [7:0] hold = 0;
  logic [4:0] key, dof = 0, dout;
  logic [4:0][15:0] fh = 0;
  pmd_mon_type mon = '0;
  pmd_mon_type m; // scratch for random monitor words
  pmd_cfg_type cfg;
  pmd_disp_type disp;
  logic cw, ccw;
  int err_count = 0, compares = 0, cyc = 0;
  logic [3:0] vw [7] = '{0, 1, 7, 5, 0, 4, 6};
  logic [31:0] vl [7] = '{1234, 32'habcd, 32'h12345678, 32'h12345678, -12345, 1234567890, 1234567890};
  always #50 clk = ~clk;
  pmd_keypad u_pmd_keypad (.clk_i(clk), .go_i(go), .idx_i(idx), .hold_i(hold), .key_o(key));
  pmd_panel #(.BOOT_CYC(50), .DEB_CYC(4)) u_pmd_panel (.ref_clk_i(clk), .srst_i(srst),
    .addr_i(addr), .wdata_i(wd), .wr_i(wr), .rd_i(rd), .rdata_o(rdata), .key_i(key),
    .servo_on_i(servo), .mon_i(mon), .fault_hist_i(fh), .do_func_i(dof), .do_o(dout),
    .jog_cw_o(cw), .jog_ccw_o(ccw), .cfg_o(cfg), .disp_o(disp));
  // five decimal digits, rightmost in the low slot
  function automatic logic [24:0] dec5(input int unsigned n);
    for (int i = 0; i < 5; i++) begin
      dec5[i*5+:5] = 5'(n % 10);
      n = n / 10;
    end
  endfunction
  // lead character plus four hex nibbles, each in its own 5-bit slot
  function automatic logic [24:0] hx5(input logic [4:0] c4, input logic [15:0] h);
    hx5 = {c4, 1'b0, h[15:12], 1'b0, h[11:8], 1'b0, h[7:4], 1'b0, h[3:0]};
  endfunction
  // monitor code to the value the rules say it shows
  function automatic logic [31:0] mexp(input logic [4:0] c);
    case (c)
      5'd11: mexp = mon.torque_pct;
      5'd12: mexp = mon.avg_load;
      5'd13: mexp = mon.peak_load;
      5'd14: mexp = mon.bus_volt;
      5'd15: mexp = mon.inertia_x10;
      5'd16: mexp = mon.stage_temp;
      5'd17: mexp = {mon.res2_hz, mon.res1_hz};
      5'd18: mexp = mon.z_pos;
      default: mexp = (c < 5'd23) ? mon.slot_val[2'(c - 5'd19)] : mon.stat_val[2'(c - 5'd23)];
    endcase
  endfunction
  task chk(input logic [31:0] s, input logic [31:0] e);
    compares++;
    if (s !== e) begin
      err_count++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask
  task wr_reg(input logic [3:0] a, input logic [31:0] d);
    @(posedge clk) {wr, addr, wd} <= {1'b1, a, d};
    @(posedge clk) wr <= 0;
  endtask
  task rd_reg(input logic [3:0] a, input logic [31:0] e);
    @(posedge clk) {rd, addr} <= {1'b1, a};
    @(posedge clk) rd <= 0;
    #1 chk(rdata, e);
  endtask
  task press(input logic [2:0] k, input logic [7:0] h);
    @(posedge clk) {go, idx, hold} <= {1'b1, k, h};
    @(posedge clk) go <= 0;
    repeat (int'(h) + 14) @(posedge clk);
  endtask
  task end_sim();
    $display("compares=%0d err_count=%0d", compares, err_count);
    if (err_count == 0 && compares > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  // hang guard
  always @(posedge clk) if (++cyc == 20000) begin
    err_count++;
    end_sim();
  end
  initial begin
    void'($urandom(49));
    foreach (fh[i]) fh[i] <= 16'($urandom);
    repeat (6) @(posedge clk);
    srst <= 0;
    repeat (60) @(posedge clk);
    rd_reg(4'hd, 32'h04);
    rd_reg(4'hc, 32'd20);
    for (int i = 0; i < 10; i++) begin
      v = (i == 0) ? 32'd26 : (i == 1) ? 32'd27 : 32'($urandom % 32);
      if (v <= 26) sel = v;
      wr_reg(4'h0, v);
      rd_reg(4'h0, sel);
    end
    wr_reg(4'h0, 32'd11);
    for (int i = 0; i < 7; i++) begin
      @(posedge clk) mon.torque_pct <= vl[i];
      wr_reg(4'h1, {28'h0, vw[i]});
      repeat (90) @(posedge clk);
      chk(disp.ch, vw[i][0] ? hx5(vw[i][2] ? (vw[i][1] ? 5'h11 : 5'h12) : 5'h10,
        vw[i][2] & vw[i][1] ? vl[i][31:16] : vl[i][15:0]) : dec5(vw[i][1] ? vl[i] / 100000
        : vw[i][2] ? vl[i] % 100000 : (i == 4 ? 12345 : vl[i])));
      chk(disp.dp, i == 4 ? 5'h18 : vw[i] == 6 ? 5'h01 : 5'h0);
    end
    // every code 11..26 in wide hex, odd codes show the high half
    for (int j = 0; j < 27; j++) m[j*32+:32] = $urandom;
    m.z_pos = 32'(int'($urandom % 10001) - 5000);
    mon <= m;
    for (int c = 11; c < 27; c++) begin
      wr_reg(4'h0, 32'(c));
      wr_reg(4'h1, c[0] ? 32'd7 : 32'd5);
      repeat (4) @(posedge clk);
      v = c[0] ? mexp(5'(c)) >> 16 : mexp(5'(c));
      chk(disp.ch, hx5(c[0] ? 5'h11 : 5'h12, v[15:0]));
    end
    wr_reg(4'h5, 32'h1234abcd);
    wr_reg(4'ha, 32'h000000c3);
    rd_reg(4'h5, 32'h0000abcd);
    rd_reg(4'ha, 32'h000000c3);
    chk({cfg.slot_ptr[1], cfg.stat_sel[2]}, 32'h00abcdc3);
    // bit 4 set so normal outputs never look like the forced mask
    dof <= {1'b1, 4'($urandom)};
    wr_reg(4'h2, 32'd406);
    wr_reg(4'h3, 32'd5);
    rd_reg(4'he, 32'd5);
    rd_reg(4'h2, 32'd1);
    wr_reg(4'h2, 32'd400);
    rd_reg(4'he, {27'h0, dof});
    servo <= 1;
    wr_reg(4'h2, 32'd406);
    rd_reg(4'he, {27'h0, dof});
    press(1, 10);
    press(2, 10);
    press(0, 10);
    // converter may need two full passes before the code shows
    repeat (80) @(posedge clk);
    chk(disp.ch, dec5(fh[1]));
    press(0, 10);
    press(1, 10);
    press(0, 10);
    rd_reg(4'hd, 32'h16);
    press(2, 10);
    press(4, 10);
    press(2, 10);
    rd_reg(4'hc, 32'd31);
    chk(cfg.jog_speed, 16'd31);
    press(0, 10);
    rd_reg(4'hd, 32'h1a);
    // hold UP then DOWN: each turns one way only while held
    for (int k = 2; k < 4; k++) begin
      @(posedge clk) {go, idx, hold} <= {1'b1, 3'(k), 8'd40};
      @(posedge clk) go <= 0;
      repeat (25) @(posedge clk);
      chk({cw, ccw}, k == 2 ? 2'b01 : 2'b10);
      repeat (40) @(posedge clk);
      chk({cw, ccw}, 2'b00);
    end
    press(1, 10);
    rd_reg(4'hd, 32'h12);
    end_sim();
  end
endmodule

// >>> pmd_pkg.sv
package pmd_pkg;
  // front-panel sequencing states
  typedef enum logic [2:0] {
    st_boot, st_monitor, st_fault_name, st_fault_show,
    st_jog_name, st_jog_edit, st_jog_run
  } pmd_state_type;
  // five characters, index 4 leftmost, plus decimal points
  typedef struct packed {
    logic [4:0][4:0] ch;
    logic [4:0]      dp;
  } pmd_disp_type;
  // live monitor sources from the drive
  typedef struct packed {
    logic [10:0][31:0] gen;        // codes 0..10
    logic [31:0]       torque_pct;
    logic [31:0]       avg_load;
    logic [31:0]       peak_load;
    logic [31:0]       bus_volt;
    logic [31:0]       inertia_x10;
    logic [31:0]       stage_temp;
    logic [15:0]       res1_hz;
    logic [15:0]       res2_hz;
    logic [31:0]       z_pos;
    logic [3:0][31:0]  slot_val;   // mapping_slot_value 1..4
    logic [3:0][31:0]  stat_val;   // status_monitor_value 1..4
  } pmd_mon_type;
  // settings handed to the drive
  typedef struct packed {
    logic [3:0][15:0] slot_ptr;    // mapping_slot_pointer
    logic [3:0][7:0]  stat_sel;    // status_monitor_selector
    logic [15:0]      jog_speed;
  } pmd_cfg_type;
endpackage
